// ---- bench/dcp_load.sv ----
// load model on the pulse pin that times its highs and periods
`default_nettype none

module dcp_load (
	input  wire logic clk_in,	// instruction clock
	input  wire logic pin_in,	// pulse pin
	output var  int   rises_out,	// rising edges seen
	output var  int   falls_out,	// falling edges seen
	output var  int   high_out,	// cycles of last high
	output var  int   per_out	// cycles rise to rise
);
	timeunit 1ns;
	timeprecision 1ns;
	bit prev_q;
	int cnt_q;

	// sample the pin each clock and time its edges
	always @(posedge clk_in) begin
		prev_q <= pin_in;
		cnt_q <= cnt_q + 1;
		if (pin_in && !prev_q) begin
			rises_out <= rises_out + 1;
			per_out <= cnt_q;
			cnt_q <= 1;
		end
		if (!pin_in && prev_q) begin
			falls_out <= falls_out + 1;
			high_out <= cnt_q;
		end
	end
endmodule : dcp_load

`default_nettype wire

// ---- bench/dcp_top_chk.sv ----
// checker of bus, pin and interrupt timing of the pulse channel
`default_nettype none

module dcp_top_chk (
	input wire logic        sys_clk_in,	// clock
	input wire logic        rst_in,	// reset
	input wire logic [5:0]  avs_address_in,	// address
	input wire logic        avs_read_in,	// read
	input wire logic        avs_write_in,	// write
	input wire logic [31:0] avs_writedata_in,	// write data
	input wire logic [3:0]  avs_byteenable_in,	// lanes
	input wire logic [31:0] avs_readdata_out,	// read data
	input wire logic        avs_waitrequest_out,	// stall
	input wire logic        pulse_output_pin_out,	// pin
	input wire logic        irq_out	// interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       req;
	logic       wr_acc;
	logic [2:0] mode_q;
	logic       mask_q;
	logic       clr_q;

	// shadows of mode, mask and status clear from accepted writes
	assign req = avs_read_in || avs_write_in;
	assign wr_acc = avs_write_in && !avs_waitrequest_out;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= 3'h0;
			mask_q <= 1'b0;
			clr_q <= 1'b0;
		end else begin
			if (wr_acc && avs_address_in == 6'h00 && avs_byteenable_in[0])
				mode_q <= avs_writedata_in[2:0];
			if (wr_acc && avs_address_in == 6'h28)
				mask_q <= avs_writedata_in[0];
			clr_q <= wr_acc && avs_address_in == 6'h24 && avs_writedata_in[0];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_wait_cause: assert property (!avs_waitrequest_out |-> $past(req))
		else $error("answer without a request");
	a_mode_off: assert property (
		mode_q != 3'h5 |=> !pulse_output_pin_out)
		else $error("pin high outside pulse mode");
	a_rise_mode: assert property ($rose(pulse_output_pin_out) |->
		$past(mode_q) == 3'h5) else $error("pin rose outside pulse mode");
	a_flag_delay: assert property ($fell(pulse_output_pin_out) &&
		$past(mode_q) == 3'h5 && mask_q && !irq_out |->
		!irq_out [*3] ##1 irq_out) else $error("event flag timing wrong");
	a_flag_hold: assert property (
		irq_out && mask_q && !clr_q |=> irq_out)
		else $error("interrupt dropped without a clear");
	a_irq_mask: assert property (!mask_q |=> !irq_out)
		else $error("masked interrupt raised");
	a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
		avs_address_in > 6'h2C |-> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (
		avs_read_in && !avs_waitrequest_out |->
		avs_readdata_out[31:16] == 16'h0) else $error("upper read bits set");
	c_rise: cover property ($rose(pulse_output_pin_out));
	c_fall: cover property ($fell(pulse_output_pin_out) && mask_q);
	c_clear: cover property (irq_out && clr_q);
endmodule : dcp_top_chk

bind dcp_top dcp_top_chk i_dcp_top_chk (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.pulse_output_pin_out(pulse_output_pin_out), .irq_out(irq_out));

`default_nettype wire

// ---- bench/dcp_top_test.sv ----
// self-checking bench of the dual compare pulse channel
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module dcp_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdat;
	logic        waitr;
	logic        pin;
	logic        irq;
	logic [15:0] v;
	int          rises, falls, high, per, f0;
	int          err_count = 0;
	int          checked = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	dcp_top i_dcp_top (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(rdat),
		.avs_waitrequest_out(waitr), .pulse_output_pin_out(pin),
		.irq_out(irq));
	dcp_load i_dcp_load (.clk_in(clk), .pin_in(pin), .rises_out(rises),
		.falls_out(falls), .high_out(high), .per_out(per));

	// counts, verdict and end of run
	task automatic close_out;
		$display("mismatches %0d of %0d checks", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// one write, held until waitrequest is sampled low
	task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		adr <= a;
		wd <= {16'h0, d};
		wr <= 1'b1;
		do @(posedge clk); while (waitr !== 1'b0);
		wr <= 1'b0;
	endtask : bus_wr

	// one read, data taken at the edge that sees waitrequest low
	task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (waitr !== 1'b0);
		d = rdat[15:0];
		rd <= 1'b0;
	endtask : bus_rd

	// wait for n more rising edges at the load
	task automatic wait_rise(input int n);
		int r0;
		r0 = rises;
		while (rises < r0 + n) @(posedge clk);
	endtask : wait_rise

	// watchdog far beyond the length of the tests
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out;
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 48; a += 4) begin
			bus_rd(a[5:0], v);
			`CHK("reset value", (a == 16 || a == 28) ? 16'hFFFF : 16'h0, v)
		end
		bus_wr(6'h30, 16'hFFFF);
		bus_rd(6'h30, v);
		`CHK("unmapped", 16'h0, v)
		// timer0 pulse: rise on 3, fall on 6, wrap on 9
		bus_wr(6'h00, 16'h0);
		bus_wr(6'h04, 16'h3);
		bus_wr(6'h08, 16'h6);
		bus_wr(6'h10, 16'h9);
		bus_wr(6'h28, 16'h1);
		bus_wr(6'h00, 16'h5);
		`CHK("pin on entry", 1'b0, pin)
		bus_wr(6'h0C, 16'h8000);
		wait_rise(3);
		`CHK("high width", 3, high)
		`CHK("period", 10, per)
		bus_rd(6'h14, v);
		`CHK("count bound", 1'b1, v <= 16'h9)
		bus_wr(6'h00, 16'h0);
		bus_rd(6'h24, v);
		`CHK("flag set", 16'h1, v)
		`CHK("irq set", 1'b1, irq)
		bus_wr(6'h24, 16'h1);
		bus_rd(6'h24, v);
		`CHK("flag clear", 16'h0, v)
		`CHK("irq clear", 1'b0, irq)
		f0 = rises;
		repeat (30) @(posedge clk);
		`CHK("no pulse off", f0, rises)
		`CHK("pin off", 1'b0, pin)
		// timer1 already running, masked: rise on 1, fall on 2, wrap on 4
		bus_wr(6'h28, 16'h0);
		bus_wr(6'h04, 16'h1);
		bus_wr(6'h08, 16'h2);
		bus_wr(6'h1C, 16'h4);
		bus_wr(6'h18, 16'h8000);
		bus_wr(6'h00, 16'hD);
		wait_rise(3);
		`CHK("tb1 high", 1, high)
		`CHK("tb1 period", 5, per)
		`CHK("irq masked", 1'b0, irq)
		bus_rd(6'h24, v);
		`CHK("tb1 flag", 16'h1, v)
		bus_wr(6'h00, 16'h0);
		// let a fall already in flight reach the flag before clearing it
		repeat (4) @(posedge clk);
		bus_wr(6'h24, 16'h1);
		// secondary beyond the period on timer0: no fall
		bus_wr(6'h04, 16'h3);
		bus_wr(6'h08, 16'hC);
		bus_wr(6'h00, 16'h5);
		wait_rise(1);
		f0 = falls;
		repeat (40) @(posedge clk);
		`CHK("no fall", f0, falls)
		`CHK("pin held", 1'b1, pin)
		bus_rd(6'h24, v);
		`CHK("no flag", 16'h0, v)
		bus_wr(6'h08, 16'h6);
		wait_rise(2);
		`CHK("resumed high", 3, high)
		bus_rd(6'h24, v);
		`CHK("resumed flag", 16'h1, v)
		close_out;
	end
endmodule : dcp_top_test

`default_nettype wire

// ---- include/dcp_cfg.svh ----
// register map, field positions, reset values and codes of the pulse channel
// Function
// - mode field bits 2:0 equal 101 forces pin low then pulses on matches
// - control bit 3 selects which of two timer counts is compared
// - count equal to primary value drives the pin high
// - count equal to secondary value drives the pin from high to low
// - each secondary match with the pin high, i.e. each trailing edge except one caused by leaving the mode, sets the event flag
// - count equal to period resets the count to zero, counting continues
// - rise, fall, flag and wrap repeat every period without software
// - channel works whether or not the timer already runs
// - event flag stays set until software clears it
// - pin rises one clock after the cycle of the primary match
// - event flag is set two clocks after the pin is driven low
// - period below secondary value gives no fall; pin stays high
// - pulses continue until the mode changes or channel is disabled
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DCP_OFS_CHAN_CTRL  6'h00
`define DCP_OFS_PRIMARY    6'h04
`define DCP_OFS_SECONDARY  6'h08
`define DCP_OFS_TB0_CTRL   6'h0C
`define DCP_OFS_TB0_PERIOD 6'h10
`define DCP_OFS_TB0_COUNT  6'h14
`define DCP_OFS_TB1_CTRL   6'h18
`define DCP_OFS_TB1_PERIOD 6'h1C
`define DCP_OFS_TB1_COUNT  6'h20
`define DCP_OFS_STATUS     6'h24
`define DCP_OFS_MASK       6'h28
`define DCP_OFS_PIN        6'h2C
`define DCP_TB_STRIDE      6'h0C

// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define DCP_MODE_LSB       0
`define DCP_MODE_MSB       2
`define DCP_TBSEL_BIT      3
`define DCP_RUN_BIT        15
`define DCP_EVENT_BIT      0
`define DCP_MODE_CONT_DUAL 3'h5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCP_RST_MODE       3'h0
`define DCP_RST_WORD       16'h0000
`define DCP_RST_PERIOD     16'hFFFF
`define DCP_RST_BIT        1'h0

`endif

// ---- include/dcp_pkg.sv ----
// shared types of the dual compare pulse channel
`default_nettype none

package dcp_pkg;

	typedef logic [15:0] dcp_word_t;	// compare, count and period width

	typedef enum logic [0:0] {
		DCP_BUS_IDLE,
		DCP_BUS_ACK
	} dcp_bus_st_t;

endpackage : dcp_pkg

`default_nettype wire

// ---- rtl/dcp_timebase.sv ----
// free running up counter with period wrap and software load
`default_nettype none
`include "dcp_cfg.svh"

module dcp_timebase #(
	parameter int W = 16
) (
	input  wire logic         sys_clk_in,	// instruction clock
	input  wire logic         rst_in,	// async reset, high
	input  wire logic         run_in,	// count enable bit
	input  wire logic [W-1:0] period_in,	// wrap value
	input  wire logic         load_in,	// software count write
	input  wire logic [W-1:0] load_val_in,	// value to load
	output logic      [W-1:0] count_out	// current count
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	// ------------------------------------------------------------------
	// next count
	// ------------------------------------------------------------------
	always_comb begin
		count_d = count_q;
		if (load_in) begin
			count_d = load_val_in;
		end else if (run_in) begin
			if (count_q == period_in) begin
				count_d = '0;
			end else begin
				count_d = count_q + W'(1);
			end
		end
	end

	// count register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_out = count_q;

endmodule : dcp_timebase

`default_nettype wire

// ---- rtl/dcp_top.sv ----
// dual compare continuous pulse channel with two timebases and avalon slave
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`default_nettype none
`include "dcp_cfg.svh"

module dcp_top #(
	parameter int W  = 16,	// compare and timer width
	parameter int NT = 2	// number of selectable timebases
) (
	input  wire logic        sys_clk_in,	// 100 MHz instruction clock
	input  wire logic        rst_in,	// async reset, high
	input  wire logic [5:0]  avs_address_in,	// byte address
	input  wire logic        avs_read_in,	// read request
	input  wire logic        avs_write_in,	// write request
	input  wire logic [31:0] avs_writedata_in,	// write data
	input  wire logic [3:0]  avs_byteenable_in,	// byte lanes
	output logic      [31:0] avs_readdata_out,	// read data
	output logic             avs_waitrequest_out,	// stall
	output logic             pulse_output_pin_out,	// pulse pin
	output logic             irq_out	// level interrupt
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// merge enabled byte lanes of the write data into a 16 bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction : merge16

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	dcp_pkg::dcp_bus_st_t bus_st_q;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic                 wr_go;
	logic                 rd_go;
	logic [2:0]           mode_q;
	logic                 tbsel_q;
	dcp_pkg::dcp_word_t   primary_q;
	dcp_pkg::dcp_word_t   secondary_q;
	logic [NT-1:0]        run_q;
	dcp_pkg::dcp_word_t   period_q [NT];
	dcp_pkg::dcp_word_t   count_w  [NT];
	logic [NT-1:0]        load_w;
	dcp_pkg::dcp_word_t   sel_count;
	logic                 active;
	logic                 prim_match;
	logic                 sec_match;
	logic                 rise;
	logic                 fall;
	logic                 pin_q;
	logic                 fall_d1_q;
	logic                 fall_d2_q;
	logic                 status_q;
	logic                 mask_q;
	logic                 irq_q;
	logic                 status_clr;

	// ------------------------------------------------------------------
	// avalon slave handshake
	// ------------------------------------------------------------------

	// a request is seen in idle, acknowledged by dropping waitrequest for
	// one cycle; a write takes effect at the edge that ends that low cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_st_q <= dcp_pkg::DCP_BUS_IDLE;
		end else begin
			case (bus_st_q)
				dcp_pkg::DCP_BUS_IDLE: begin
					if (avs_read_in || avs_write_in) begin
						bus_st_q <= dcp_pkg::DCP_BUS_ACK;
					end
				end
				dcp_pkg::DCP_BUS_ACK: begin
					bus_st_q <= dcp_pkg::DCP_BUS_IDLE;
				end
				default: begin
					bus_st_q <= dcp_pkg::DCP_BUS_IDLE;
				end
			endcase
		end
	end

	// waitrequest is high except in the acknowledge cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'h1;
		end else begin
			avs_waitrequest_out <= !((bus_st_q == dcp_pkg::DCP_BUS_IDLE) &&
				(avs_read_in || avs_write_in));
		end
	end

	assign wr_go = (bus_st_q == dcp_pkg::DCP_BUS_ACK) && avs_write_in;
	assign rd_go = (bus_st_q == dcp_pkg::DCP_BUS_IDLE) && avs_read_in;

	// ------------------------------------------------------------------
	// read multiplexer
	// ------------------------------------------------------------------

	// unmapped offsets read as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address_in)
			`DCP_OFS_CHAN_CTRL: begin
				rdata_d[`DCP_MODE_MSB:`DCP_MODE_LSB] = mode_q;
				rdata_d[`DCP_TBSEL_BIT] = tbsel_q;
			end
			`DCP_OFS_PRIMARY:    rdata_d[15:0] = primary_q;
			`DCP_OFS_SECONDARY:  rdata_d[15:0] = secondary_q;
			`DCP_OFS_TB0_CTRL:   rdata_d[`DCP_RUN_BIT] = run_q[0];
			`DCP_OFS_TB0_PERIOD: rdata_d[15:0] = period_q[0];
			`DCP_OFS_TB0_COUNT:  rdata_d[15:0] = count_w[0];
			`DCP_OFS_TB1_CTRL:   rdata_d[`DCP_RUN_BIT] = run_q[1];
			`DCP_OFS_TB1_PERIOD: rdata_d[15:0] = period_q[1];
			`DCP_OFS_TB1_COUNT:  rdata_d[15:0] = count_w[1];
			`DCP_OFS_STATUS:     rdata_d[`DCP_EVENT_BIT] = status_q;
			`DCP_OFS_MASK:       rdata_d[`DCP_EVENT_BIT] = mask_q;
			`DCP_OFS_PIN:        rdata_d[0] = pin_q;
			default:             rdata_d = 32'h0000_0000;
		endcase
	end

	// read data is captured when the read is seen and held until the next
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_out = rdata_q;

	// ------------------------------------------------------------------
	// channel control and compare values
	// ------------------------------------------------------------------

	// mode field and timebase select
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q  <= `DCP_RST_MODE;
			tbsel_q <= `DCP_RST_BIT;
		end else if (wr_go && avs_address_in == `DCP_OFS_CHAN_CTRL &&
			avs_byteenable_in[0]) begin
			mode_q  <= avs_writedata_in[`DCP_MODE_MSB:`DCP_MODE_LSB];
			tbsel_q <= avs_writedata_in[`DCP_TBSEL_BIT];
		end
	end

	// primary and secondary compare values
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			primary_q   <= `DCP_RST_WORD;
			secondary_q <= `DCP_RST_WORD;
		end else if (wr_go) begin
			if (avs_address_in == `DCP_OFS_PRIMARY) begin
				primary_q <= merge16(primary_q, avs_writedata_in,
					avs_byteenable_in);
			end
			if (avs_address_in == `DCP_OFS_SECONDARY) begin
				secondary_q <= merge16(secondary_q, avs_writedata_in,
					avs_byteenable_in);
			end
		end
	end

	// ------------------------------------------------------------------
	// timebases
	// ------------------------------------------------------------------
	generate
		for (genvar t = 0; t < NT; t++) begin : g_tb
			localparam logic [5:0] CTRL_OFS =
				6'(`DCP_OFS_TB0_CTRL + t * `DCP_TB_STRIDE);
			localparam logic [5:0] PER_OFS =
				6'(`DCP_OFS_TB0_PERIOD + t * `DCP_TB_STRIDE);
			localparam logic [5:0] CNT_OFS =
				6'(`DCP_OFS_TB0_COUNT + t * `DCP_TB_STRIDE);

			// run bit and period; counting is independent of the mode
			always_ff @(posedge sys_clk_in or posedge rst_in) begin
				if (rst_in) begin
					run_q[t]    <= `DCP_RST_BIT;
					period_q[t] <= `DCP_RST_PERIOD;
				end else if (wr_go) begin
					if (avs_address_in == CTRL_OFS &&
						avs_byteenable_in[1]) begin
						run_q[t] <= avs_writedata_in[`DCP_RUN_BIT];
					end
					if (avs_address_in == PER_OFS) begin
						period_q[t] <= merge16(period_q[t],
							avs_writedata_in, avs_byteenable_in);
					end
				end
			end

			// software write of the count
			assign load_w[t] = wr_go && (avs_address_in == CNT_OFS) &&
				(avs_byteenable_in[1:0] != 2'h0);

			dcp_timebase #(
				.W (W)
			) u_tb (
				.sys_clk_in  (sys_clk_in),
				.rst_in      (rst_in),
				.run_in      (run_q[t]),
				.period_in   (period_q[t]),
				.load_in     (load_w[t]),
				.load_val_in (merge16(count_w[t], avs_writedata_in,
					avs_byteenable_in)),
				.count_out   (count_w[t])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// compare logic
	// ------------------------------------------------------------------

	// selected count; the mode may be entered with the timer running
	assign sel_count = tbsel_q ? count_w[1] : count_w[0];

	// mode decode gates all pulse generation
	assign active = (mode_q == `DCP_MODE_CONT_DUAL);

	// exact equality, tested every clock
	assign prim_match = (sel_count == primary_q);
	assign sec_match  = (sel_count == secondary_q);

	// fall needs a high pin; a period below the secondary value never
	// reaches the match, so the pin simply stays high
	assign fall = active && pin_q && sec_match;
	assign rise = active && !fall && prim_match;

	// pulse pin: low outside the mode, changes one clock after a match
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_q <= 1'h0;
		end else if (!active) begin
			pin_q <= 1'h0;
		end else if (fall) begin
			pin_q <= 1'h0;
		end else if (rise) begin
			pin_q <= 1'h1;
		end
	end

	assign pulse_output_pin_out = pin_q;

	// ------------------------------------------------------------------
	// event flag and interrupt
	// ------------------------------------------------------------------

	// two stage delay from the falling edge to the flag
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fall_d1_q <= 1'h0;
			fall_d2_q <= 1'h0;
		end else begin
			fall_d1_q <= fall;
			fall_d2_q <= fall_d1_q;
		end
	end

	assign status_clr = wr_go && avs_address_in == `DCP_OFS_STATUS &&
		avs_byteenable_in[0] && avs_writedata_in[`DCP_EVENT_BIT];

	// sticky flag, write one to clear; a new event wins over the clear
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_q <= `DCP_RST_BIT;
		end else if (fall_d2_q) begin
			status_q <= 1'h1;
		end else if (status_clr) begin
			status_q <= 1'h0;
		end
	end

	// interrupt mask
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mask_q <= `DCP_RST_BIT;
		end else if (wr_go && avs_address_in == `DCP_OFS_MASK &&
			avs_byteenable_in[0]) begin
			mask_q <= avs_writedata_in[`DCP_EVENT_BIT];
		end
	end

	// level interrupt, registered one clock behind status and mask
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_q <= 1'h0;
		end else begin
			irq_q <= status_q && mask_q;
		end
	end

	assign irq_out = irq_q;

endmodule : dcp_top

`default_nettype wire
